// ===== verilog/tmcu_pkg.sv
// Purpose: Shared constants for the timer match compare unit
// Assumes: 32-bit AXI4-Lite register bus, 8-bit byte address
// Notes:   Mode codes are 4-bit values of the match_mode_sel field
package tmcu_pkg;
    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL   = 8'h00;
    localparam logic [7:0] OFS_MATCH_LO  = 8'h04;
    localparam logic [7:0] OFS_MATCH_HI  = 8'h08;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h0C;
    localparam logic [7:0] OFS_IRQ_CLR   = 8'h10;
    localparam logic [7:0] OFS_IRQ_EN    = 8'h14;
    localparam logic [7:0] OFS_STATE     = 8'h18;
    // ----------------------------------------------------------------
    // Reset values and field positions
    // ----------------------------------------------------------------
    localparam logic [7:0] CONTROL_RST   = 8'h00;
    localparam logic [7:0] MATCH_RST     = 8'h00;
    localparam logic [0:0] IRQ_EN_RST    = 1'h0;
    localparam int         MODE_LSB      = 0;
    localparam int         MODE_MSB      = 3;
    localparam int         STATE_LATCH   = 0;
    localparam int         STATE_OWN     = 1;
    localparam int         STATE_MATCH   = 2;
    // ----------------------------------------------------------------
    // Compare mode codes
    // ----------------------------------------------------------------
    localparam logic [3:0] MODE_OFF      = 4'h0;
    localparam logic [3:0] MODE_TOGGLE   = 4'h2;
    localparam logic [3:0] MODE_SET      = 4'h8;
    localparam logic [3:0] MODE_CLEAR    = 4'h9;
    localparam logic [3:0] MODE_SWINT    = 4'hA;
    localparam logic [3:0] MODE_SPECIAL  = 4'hB;
    // ----------------------------------------------------------------
    // Bus responses
    // ----------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;
endpackage

// ===== verilog/tmcu_match_if.sv
// Purpose: Carrier between register file and match engine
// Assumes: Single aclk domain
// Notes:   Engine outputs are combinational where marked in the engine
`timescale 1ns/1ns
interface tmcu_match_if;
    logic [3:0]  mode;        // Selected compare mode
    logic [15:0] match_value; // Match value high:low
    logic        ctrl_zero;   // Pulse: control written with zero
    logic        hit;         // Pulse: compare event this cycle
    logic        latch;       // Compare output latch
    logic        own;         // Compare drives the pin
    logic        match_now;   // Equality this cycle
    modport regs (output mode, match_value, ctrl_zero, input hit, latch, own, match_now);
    modport core (input mode, match_value, ctrl_zero, output hit, latch, own, match_now);
endinterface // tmcu_match_if

// ===== verilog/tmcu_pin_route.sv
// Purpose: Route the compare output to one of two package pins
// Assumes: Relocation bit is held by a register outside the unit
// Notes:   The unselected pin is released to its port logic
`timescale 1ns/1ns
module tmcu_pin_route (
    input  wire logic relocate,  // Relocation select
    input  wire logic value,     // Compare output latch
    input  wire logic own,       // Compare owns the pin
    output logic      pin0_out,  // Default pin value
    output logic      pin0_oe,   // Default pin driven
    output logic      pin1_out,  // Alternate pin value
    output logic      pin1_oe    // Alternate pin driven
);
    always_comb begin
        pin0_out = value & ~relocate;
        pin1_out = value & relocate;
        pin0_oe  = own & ~relocate;
        pin1_oe  = own & relocate;
    end
endmodule // tmcu_pin_route

// ===== verilog/tmcu_match.sv
// Purpose: 16-bit match engine with latch, trigger and event
// Assumes: Timer count comes from logic on aclk
// Notes:   A match that persists raises one event only
`timescale 1ns/1ns
module tmcu_match (
    input  wire logic        aclk,        // System clock
    input  wire logic        aresetn,     // Sync reset, low
    tmcu_match_if.core       mif,         // Register side
    input  wire logic [15:0] timer_count, // Timer high:low
    input  wire logic        adc_enable,  // Converter enabled
    output logic             timer_reset, // Clear timer at its tick
    output logic             adc_start    // Conversion start pulse
);
    logic match_q;
    logic adc_q;
    logic latch_q;

    function automatic logic is_cmp(input logic [3:0] m);
        is_cmp = (m == tmcu_pkg::MODE_TOGGLE) || (m == tmcu_pkg::MODE_SET) ||
                 (m == tmcu_pkg::MODE_CLEAR) || (m == tmcu_pkg::MODE_SWINT) ||
                 (m == tmcu_pkg::MODE_SPECIAL);
    endfunction

    function automatic logic drives_pin(input logic [3:0] m);
        drives_pin = (m == tmcu_pkg::MODE_TOGGLE) || (m == tmcu_pkg::MODE_SET) ||
                     (m == tmcu_pkg::MODE_CLEAR);
    endfunction

    // ----------------------------------------------------------------
    // Compare and event
    // ----------------------------------------------------------------
    assign mif.match_now = (mif.match_value == timer_count);
    assign mif.hit       = mif.match_now & ~match_q & is_cmp(mif.mode);
    assign mif.own       = drives_pin(mif.mode);
    assign mif.latch     = latch_q;
    // Level, so a rewrite of the match value withdraws it before the tick
    assign timer_reset   = (mif.mode == tmcu_pkg::MODE_SPECIAL) & mif.match_now;
    assign adc_start     = adc_q;

    // Runs on aclk only; while it is stopped nothing here advances
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            match_q <= 1'b0;
        end else begin
            match_q <= mif.match_now;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latch_q <= 1'b0;
        end else if (mif.ctrl_zero) begin
            latch_q <= 1'b0;
        end else if (mif.hit) begin
            unique case (mif.mode)
                tmcu_pkg::MODE_TOGGLE: latch_q <= ~latch_q;
                tmcu_pkg::MODE_SET:    latch_q <= 1'b1;
                tmcu_pkg::MODE_CLEAR:  latch_q <= 1'b0;
                default:               latch_q <= latch_q;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            adc_q <= 1'b0;
        end else begin
            adc_q <= mif.hit & (mif.mode == tmcu_pkg::MODE_SPECIAL) & adc_enable;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence set_hit_s;
        mif.hit && mif.mode == tmcu_pkg::MODE_SET && !mif.ctrl_zero;
    endsequence

    set_action_a: assert property (@(posedge aclk) disable iff (!aresetn)
        set_hit_s |=> latch_q) else $error("set mode did not raise latch");
    toggle_action_a: assert property (@(posedge aclk) disable iff (!aresetn)
        mif.hit && mif.mode == tmcu_pkg::MODE_TOGGLE && !mif.ctrl_zero |=> latch_q != $past(latch_q))
        else $error("toggle mode did not flip latch");
    zero_ctrl_a: assert property (@(posedge aclk) disable iff (!aresetn)
        mif.ctrl_zero |=> !latch_q) else $error("zero control left latch high");
    swint_pin_a: assert property (@(posedge aclk) disable iff (!aresetn)
        mif.mode == tmcu_pkg::MODE_SWINT && !mif.ctrl_zero |-> !mif.own ##1 $stable(latch_q))
        else $error("interrupt-only mode touched the pin");
    special_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
        mif.mode == tmcu_pkg::MODE_SPECIAL && mif.match_value == timer_count |-> timer_reset && !mif.own)
        else $error("special mode missed timer reset");
    withdrawn_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
        timer_reset |-> mif.match_value == timer_count) else $error("timer reset without match");
    adc_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
        mif.hit && mif.mode == tmcu_pkg::MODE_SPECIAL && adc_enable |=> adc_start ##1 !adc_start)
        else $error("conversion start not a single pulse");
    one_event_a: assert property (@(posedge aclk) disable iff (!aresetn)
        mif.hit |=> !mif.hit) else $error("event repeated on held match");
endmodule // tmcu_match

// ===== verilog/tmcu_top.sv
// Purpose: Timer match compare unit with AXI4-Lite registers
// Assumes: Timer count and adc_enable come from logic on aclk
// Notes:   One write and one read in flight; reads answer in one cycle, writes in two
// Contract
// - The full 16-bit match value is compared with the 16-bit timer count every cycle.
// - A match toggles, sets or clears the latch, fires the trigger, or only interrupts, by mode.
// - The match flag is set in the same cycle as the match action in every compare mode.
// - In interrupt-only mode the pin stays with the port and only the flag is raised.
// - In special event mode a match resets the timer and starts a conversion if enabled, pin untouched.
// - The trigger is asserted at once on the match; the timer clears on its next clock edge.
// - The trigger reset of the timer does not set the timer overflow flag.
// - If the match value changes so the match is gone before the timer edge, no reset occurs.
// - Writing zero to the whole control register forces the compare latch low, port latch untouched.
// - The compare works from the system clock and need not work while it is stopped.
// - The compare pin can be routed to an alternate pin by an outside relocation bit.
// - The match value is held as two byte registers, low and high.
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
module tmcu_top (
    input  wire logic        aclk,          // System clock, 100 MHz
    input  wire logic        aresetn,       // Sync reset, active low
    input  wire logic [7:0]  s_awaddr,      // Write address
    input  wire logic        s_awvalid,     // Write address valid
    output logic             s_awready,     // Write address ready
    input  wire logic [31:0] s_wdata,       // Write data
    input  wire logic [3:0]  s_wstrb,       // Write strobes
    input  wire logic        s_wvalid,      // Write data valid
    output logic             s_wready,      // Write data ready
    output logic [1:0]       s_bresp,       // Write response
    output logic             s_bvalid,      // Write response valid
    input  wire logic        s_bready,      // Write response ready
    input  wire logic [7:0]  s_araddr,      // Read address
    input  wire logic        s_arvalid,     // Read address valid
    output logic             s_arready,     // Read address ready
    output logic [31:0]      s_rdata,       // Read data
    output logic [1:0]       s_rresp,       // Read response
    output logic             s_rvalid,      // Read data valid
    input  wire logic        s_rready,      // Read data ready
    input  wire logic [15:0] timer_count,   // Timer count high:low
    input  wire logic        adc_enable,    // Converter enabled
    input  wire logic        pin_relocate,  // Pin relocation bit
    output logic             timer_reset,   // Clear timer at its next tick
    output logic             adc_start,     // Start conversion pulse
    output logic             pin0_out,      // Default pin value
    output logic             pin0_oe,       // Default pin driven
    output logic             pin1_out,      // Alternate pin value
    output logic             pin1_oe,       // Alternate pin driven
    output logic             irq            // Match interrupt, level
);
    tmcu_match_if mif ();

    logic [7:0]  control_q;
    logic [7:0]  match_lo_q;
    logic [7:0]  match_hi_q;
    logic        flag_q;
    logic        enable_q;
    logic        aw_full_q;
    logic        w_full_q;
    logic [7:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic        wr_go;
    logic        wr_lane0;
    logic        clr_req;

    // Unmapped offsets answer SLVERR and change nothing
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == tmcu_pkg::OFS_CONTROL) || (a == tmcu_pkg::OFS_MATCH_LO) ||
                 (a == tmcu_pkg::OFS_MATCH_HI) || (a == tmcu_pkg::OFS_IRQ_STAT) ||
                 (a == tmcu_pkg::OFS_IRQ_CLR) || (a == tmcu_pkg::OFS_IRQ_EN) ||
                 (a == tmcu_pkg::OFS_STATE);
    endfunction

    // ----------------------------------------------------------------
    // Write channel
    // ----------------------------------------------------------------
    // Address and data park apart, so either may arrive first
    assign s_awready = ~aw_full_q;
    assign s_wready  = ~w_full_q;
    assign s_bvalid  = bvalid_q;
    assign s_bresp   = bresp_q;
    assign wr_go     = aw_full_q & w_full_q & ~bvalid_q;
    assign wr_lane0  = wr_go & w_strb_q[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= 8'h00;
        end else if (s_awvalid && !aw_full_q) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_awaddr;
        end else if (wr_go) begin
            aw_full_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (s_wvalid && !w_full_q) begin
            w_full_q <= 1'b1;
            w_data_q <= s_wdata;
            w_strb_q <= s_wstrb;
        end else if (wr_go) begin
            w_full_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= tmcu_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= mapped(aw_addr_q) ? tmcu_pkg::RESP_OKAY : tmcu_pkg::RESP_SLVERR;
        end else if (s_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control_q <= tmcu_pkg::CONTROL_RST;
        end else if (wr_lane0 && aw_addr_q == tmcu_pkg::OFS_CONTROL) begin
            control_q <= w_data_q[7:0];
        end
    end

    // Two byte registers; a rewrite takes effect on the next compare
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            match_lo_q <= tmcu_pkg::MATCH_RST;
            match_hi_q <= tmcu_pkg::MATCH_RST;
        end else if (wr_lane0 && aw_addr_q == tmcu_pkg::OFS_MATCH_LO) begin
            match_lo_q <= w_data_q[7:0];
        end else if (wr_lane0 && aw_addr_q == tmcu_pkg::OFS_MATCH_HI) begin
            match_hi_q <= w_data_q[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_q <= tmcu_pkg::IRQ_EN_RST;
        end else if (wr_lane0 && aw_addr_q == tmcu_pkg::OFS_IRQ_EN) begin
            enable_q <= w_data_q[0];
        end
    end

    // Set wins over a clear in the same cycle, so no event is lost
    assign clr_req = wr_lane0 && aw_addr_q == tmcu_pkg::OFS_IRQ_CLR && w_data_q[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_q <= 1'b0;
        end else if (mif.hit) begin
            flag_q <= 1'b1;
        end else if (clr_req) begin
            flag_q <= 1'b0;
        end
    end

    assign irq = flag_q & enable_q;

    assign mif.mode        = control_q[tmcu_pkg::MODE_MSB:tmcu_pkg::MODE_LSB];
    assign mif.match_value = {match_hi_q, match_lo_q};
    // Whole register must be zero, including the lane's upper bits
    assign mif.ctrl_zero   = wr_lane0 && aw_addr_q == tmcu_pkg::OFS_CONTROL && w_data_q[7:0] == 8'h00;

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    // Read data is registered and stands until rready
    assign s_arready = ~rvalid_q;
    assign s_rvalid  = rvalid_q;
    assign s_rdata   = rdata_q;
    assign s_rresp   = rresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= tmcu_pkg::RESP_OKAY;
        end else if (s_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rresp_q  <= mapped(s_araddr) ? tmcu_pkg::RESP_OKAY : tmcu_pkg::RESP_SLVERR;
            unique case (s_araddr)
                tmcu_pkg::OFS_CONTROL:  rdata_q <= {24'h000000, control_q};
                tmcu_pkg::OFS_MATCH_LO: rdata_q <= {24'h000000, match_lo_q};
                tmcu_pkg::OFS_MATCH_HI: rdata_q <= {24'h000000, match_hi_q};
                tmcu_pkg::OFS_IRQ_STAT: rdata_q <= {31'h00000000, flag_q};
                tmcu_pkg::OFS_IRQ_EN:   rdata_q <= {31'h00000000, enable_q};
                tmcu_pkg::OFS_STATE:    rdata_q <= {29'h00000000, mif.match_now, mif.own, mif.latch};
                default:                rdata_q <= 32'h0000_0000;
            endcase
        end else if (s_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Engine and pin routing
    // ----------------------------------------------------------------
    // The reset line is a plain clear; the timer raises no overflow for it
    tmcu_match u_match (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .mif         (mif),
        .timer_count (timer_count),
        .adc_enable  (adc_enable),
        .timer_reset (timer_reset),
        .adc_start   (adc_start)
    );

    tmcu_pin_route u_route (
        .relocate (pin_relocate),
        .value    (mif.latch),
        .own      (mif.own),
        .pin0_out (pin0_out),
        .pin0_oe  (pin0_oe),
        .pin1_out (pin1_out),
        .pin1_oe  (pin1_oe)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence flag_set_s;
        mif.hit ##1 flag_q;
    endsequence

    flag_same_cycle_a: assert property (@(posedge aclk) disable iff (!aresetn)
        mif.hit |-> flag_set_s) else $error("flag not set with match action");

    set_beats_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        mif.hit && clr_req |=> flag_q) else $error("clear beat a new event");

    match_bytes_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_lane0 && aw_addr_q == tmcu_pkg::OFS_MATCH_HI |=> match_hi_q == $past(w_data_q[7:0]))
        else $error("high byte not stored");

    irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
        irq == (flag_q && enable_q)) else $error("interrupt level mismatch");

    route_default_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !pin_relocate && mif.own |-> pin0_oe && !pin1_oe && pin0_out == mif.latch)
        else $error("pin routing wrong");

    write_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go |=> s_bvalid) else $error("write not answered");

    // Bus answers must stand until the master takes them
    bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp)) else $error("write answer dropped");

    rdata_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata)) else $error("read answer dropped");

    read_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_arvalid && s_arready |=> s_rvalid) else $error("read not answered");

    bad_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go && !mapped(aw_addr_q) |=> s_bresp == tmcu_pkg::RESP_SLVERR)
        else $error("bad write answered okay");

    ctrl_store_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_lane0 && aw_addr_q == tmcu_pkg::OFS_CONTROL |=> control_q == $past(w_data_q[7:0]))
        else $error("control not stored");

    match_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_lane0 && aw_addr_q == tmcu_pkg::OFS_MATCH_LO |=> match_lo_q == $past(w_data_q[7:0]))
        else $error("low byte not stored");

    enable_store_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_lane0 && aw_addr_q == tmcu_pkg::OFS_IRQ_EN |=> enable_q == $past(w_data_q[0]))
        else $error("enable not stored");

    flag_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        flag_q && !clr_req |=> flag_q) else $error("flag lost without clear");

    flag_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clr_req && !mif.hit |=> !flag_q) else $error("clear did not drop flag");

    route_alt_a: assert property (@(posedge aclk) disable iff (!aresetn)
        pin_relocate |-> !pin0_oe && !pin0_out && pin1_oe == mif.own && pin1_out == mif.latch)
        else $error("alternate routing wrong");

    pin_release_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !mif.own |-> !pin0_oe && !pin1_oe) else $error("pin driven without ownership");
endmodule // tmcu_top

// ===== verification/tmcu_timer_model.sv
// Purpose: Partner model of the 16-bit timer driving the compare unit
// Assumes: Bench loads come on aclk; tick is every fourth aclk
// Notes:   A clear request is honoured only at the timer's own tick
`timescale 1ns/1ns
module tmcu_timer_model (
    input  wire logic        aclk,     // System clock
    input  wire logic        aresetn,  // Sync reset, low
    input  wire logic        load,     // Load count now
    input  wire logic [15:0] load_val, // Value to load
    input  wire logic        clr_req,  // Clear at next tick
    output logic [15:0]      count_q,  // Timer count
    output logic             ovf_q     // Overflow flag
);
    logic [1:0] pre_q;
    // Quarter rate keeps the timer synchronous but off the raw clock
    always_ff @(posedge aclk) begin
        pre_q <= aresetn ? pre_q + 2'h1 : 2'h0;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_q <= 16'h0000;
            ovf_q   <= 1'h0;
        end else if (load) begin
            count_q <= load_val;
        end else if (pre_q == 2'h3) begin
            if (clr_req) begin
                count_q <= 16'h0000;
            end else begin
                count_q <= count_q + 16'h0001;
                if (count_q == 16'hFFFF) begin
                    ovf_q <= 1'h1;
                end
            end
        end
    end
endmodule // tmcu_timer_model

// ===== verification/testbench.sv
// Purpose: Register-level test of the timer match compare unit
// Assumes: Timer partner model on aclk, quarter-rate tick
// Notes:   Bus tasks wait for the answer with no bound; fire waits under a bounded count
`timescale 1ns/1ns
module testbench;
    logic        aclk = 1'h0, aresetn = 1'h0, ld = 1'h0;
    logic [7:0]  s_awaddr = 8'h00, s_araddr = 8'h00;
    logic [31:0] s_wdata = 32'h0, rdat;
    logic        s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0;
    logic        s_arvalid = 1'h0, s_rready = 1'h0;
    logic        adc_enable = 1'h0, pin_relocate = 1'h0;
    logic [15:0] ld_val = 16'h0000, tcount;
    logic [1:0]  s_bresp, s_rresp, rrsp;
    logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, ovf;
    logic        timer_reset, adc_start, pin0_out, pin0_oe, pin1_out, pin1_oe, irq;
    logic [31:0] s_rdata;
    logic [3:0]  modes [4];
    logic        eout [4], eoe [4];
    int          n_fail = 0, checked = 0, adc_n = 0, i;

    always #5 aclk = ~aclk;
    always @(posedge aclk) if (adc_start === 1'h1) adc_n++;

    tmcu_top dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
        .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(4'hF), .s_wvalid(s_wvalid),
        .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
        .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready), .timer_count(tcount),
        .adc_enable(adc_enable), .pin_relocate(pin_relocate), .timer_reset(timer_reset),
        .adc_start(adc_start), .pin0_out(pin0_out), .pin0_oe(pin0_oe), .pin1_out(pin1_out),
        .pin1_oe(pin1_oe), .irq(irq));
    tmcu_timer_model tmr (.aclk(aclk), .aresetn(aresetn), .load(ld), .load_val(ld_val),
        .clr_req(timer_reset), .count_q(tcount), .ovf_q(ovf));

    task automatic end_sim;
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_awaddr  <= a;
        s_wdata   <= d;
        s_awvalid <= 1'h1;
        s_wvalid  <= 1'h1;
        s_bready  <= 1'h1;
        while (!(s_bvalid && s_bready)) begin
            @(posedge aclk);
            if (s_awready) s_awvalid <= 1'h0;
            if (s_wready) s_wvalid <= 1'h0;
        end
        s_bready <= 1'h0;
        chk(s_bresp, (a > 8'h18) ? tmcu_pkg::RESP_SLVERR : tmcu_pkg::RESP_OKAY);
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_araddr  <= a;
        s_arvalid <= 1'h1;
        s_rready  <= 1'h1;
        while (!(s_rvalid && s_rready)) begin
            @(posedge aclk);
            if (s_arready) s_arvalid <= 1'h0;
            rdat = s_rdata;
            rrsp = s_rresp;
        end
        s_rready <= 1'h0;
    endtask
    // Load the timer just short of the match and wait for the event
    task automatic fire;
        int n;
        @(posedge aclk);
        ld_val <= 16'hA557;
        ld     <= 1'h1;
        @(posedge aclk);
        ld <= 1'h0;
        for (n = 0; n < 200 && irq !== 1'h1; n++) @(posedge aclk);
        chk(irq, 1'h1);
    endtask

    initial begin
        #100000;
        n_fail++;
        end_sim();
    end
    initial begin
        modes = '{tmcu_pkg::MODE_SET, tmcu_pkg::MODE_CLEAR, tmcu_pkg::MODE_TOGGLE, tmcu_pkg::MODE_SWINT};
        eout  = '{1'h1, 1'h0, 1'h1, 1'h1};
        eoe   = '{1'h1, 1'h1, 1'h1, 1'h0};
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        rd(tmcu_pkg::OFS_CONTROL);
        chk(rdat, 32'h0);
        rd(8'h40);
        chk(rrsp, tmcu_pkg::RESP_SLVERR);
        wr(tmcu_pkg::OFS_MATCH_LO, 32'h5A);
        wr(tmcu_pkg::OFS_MATCH_HI, 32'hA5);
        wr(tmcu_pkg::OFS_IRQ_EN, 32'h1);
        rd(tmcu_pkg::OFS_MATCH_HI);
        chk(rdat, 32'hA5);
        wr(tmcu_pkg::OFS_CONTROL, {28'h0, tmcu_pkg::MODE_SET});
        ld_val <= 16'h0058;
        ld     <= 1'h1;
        @(posedge aclk);
        ld <= 1'h0;
        repeat (20) @(posedge aclk);
        chk(irq, 1'h0);
        for (i = 0; i < 4; i++) begin
            wr(tmcu_pkg::OFS_CONTROL, {28'h0, modes[i]});
            fire();
            chk(pin0_out, eout[i]);
            chk(pin0_oe, eoe[i]);
            wr(tmcu_pkg::OFS_IRQ_CLR, 32'h1);
            chk(irq, 1'h0);
            if (i == 2) begin
                pin_relocate <= 1'h1;
                repeat (2) @(posedge aclk);
                chk({pin1_oe, pin1_out, pin0_oe}, 3'h6);
                pin_relocate <= 1'h0;
            end
        end
        wr(tmcu_pkg::OFS_CONTROL, 32'h0);
        rd(tmcu_pkg::OFS_STATE);
        chk(rdat[0], 1'h0);
        wr(tmcu_pkg::OFS_CONTROL, {28'h0, tmcu_pkg::MODE_SPECIAL});
        adc_enable <= 1'h1;
        fire();
        repeat (8) @(posedge aclk);
        chk(tcount < 16'h0010, 1'h1);
        chk(ovf, 1'h0);
        chk(adc_n, 1);
        chk(pin0_oe, 1'h0);
        // Hold the timer on a match, then move the match away before it ticks
        ld_val <= 16'hA55A;
        ld     <= 1'h1;
        wr(tmcu_pkg::OFS_MATCH_LO, 32'h0);
        ld <= 1'h0;
        repeat (8) @(posedge aclk);
        chk(tcount > 16'hA55A, 1'h1);
        end_sim();
    end
endmodule // testbench
